// file: prfc_top.sv
// reset sequencer and stream delimiter framing for a 10/100 phy
// Overview of operation
// - reset isolates mac, tristates line; hardware reset also powers down
// - exit steps in order, then release mac
// - mac pins released within 640 ns
// - first five exit steps within sixteen clocks
// - reset completes when tx/rx clocks run
// - power-on reset lasts about 20 us
// - external reset ignored during power-on reset
// - bit 0.15 write gives two-cycle reset
// - software reset skips power-down
// - reset completion clears bit 0.15
// - software reset keeps captured address
// - hardware/power-on never set bit 0.15
// - reset input low, bit 0.15 high
// - 100M tx: ssd replaces first preamble octet, esd appended
// - 100M rx: ssd to preamble, stop at esd
// - 100M idle sends unscrambled all-ones idle, judges link
// - 10M tx: no ssd, idle delimiter appended
// - 10M rx: present preamble after lock
// - 10M idle sends/detects link pulses
`include "prfc_defines.svh"
module prfc_top #(
  parameter int unsigned PorCycles   = `PRFC_POR_CYC,
  parameter int unsigned ClkUpCycles = `PRFC_CLKUP_CYC
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       ext_rst_low_in,
  input  wire logic                       swRstWr,
  input  wire logic [`PRFC_ADDR_W-1:0]    addrStrap,
  input  wire logic                       speed100,
  input  wire logic                       macTxEn,
  input  wire logic [3:0]                 macTxD,
  input  wire prfc_pkg::prfc_sym_t        lineRx,
  input  wire logic                       rxLock10,
  input  wire logic                       rxIdleSeen,
  output logic                            macRxDv,
  output logic [3:0]                      macRxD,
  output logic                            macClkOn,
  output logic                            macIsolate,
  output logic                            lineTxOe,
  output prfc_pkg::prfc_sym_t             lineTx,
  output logic                            powerDown,
  output logic                            swRstBit,
  output logic [`PRFC_ADDR_W-1:0]         phyAddr,
  output logic                            mgmtReady,
  output logic                            linkUp,
  output logic                            latchClr
);
  localparam logic [`PRFC_CNT_W-1:0] PorCnt   = `PRFC_CNT_W'(PorCycles);
  localparam logic [`PRFC_CNT_W-1:0] ClkCnt   = `PRFC_CNT_W'(ClkUpCycles);
  localparam logic [`PRFC_CNT_W-1:0] HwMin    = `PRFC_CNT_W'(`PRFC_HW_MIN_LOW);
  localparam logic [`PRFC_CNT_W-1:0] ExitCnt  = `PRFC_CNT_W'(`PRFC_EXIT_STEPS_REF - 1);
  localparam logic [`PRFC_CNT_W-1:0] SwCnt    = `PRFC_CNT_W'(`PRFC_SW_RST_CYC - 1);
  localparam logic [`PRFC_CNT_W-1:0] CntOne   = `PRFC_CNT_W'(1);

  // three-stage synchroniser on the reset pin
  logic [2:0] extSync_r;               // stage 0 read only by stage 1
  logic       extLow;                  // agreed low level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      extSync_r <= 3'h7;
    end else begin
      extSync_r <= {extSync_r[1:0], ext_rst_low_in};
    end
  end
  assign extLow = ~extSync_r[1] & ~extSync_r[2];

  // sequencer state
  prfc_pkg::prfc_state_t         st_r, st_nxt;
  logic [`PRFC_CNT_W-1:0]        cnt_r, cnt_nxt;      // phase counter
  logic [`PRFC_CNT_W-1:0]        low_r, low_nxt;      // pin low duration
  logic                          swKind_r, swKind_nxt; // reset came from software

  // next state of the sequencer
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r + CntOne;
    low_nxt    = extLow ? ((low_r == HwMin) ? low_r : low_r + CntOne) : '0;
    swKind_nxt = swKind_r;
    unique case (st_r)
      prfc_pkg::ST_POR: begin
        low_nxt = '0;
        if (cnt_r >= PorCnt - CntOne) begin
          st_nxt     = prfc_pkg::ST_EXIT;
          cnt_nxt    = '0;
          swKind_nxt = 1'b0;
        end
      end
      prfc_pkg::ST_HOLD: begin
        // wait for the pin to rise again
        if (!extLow) begin
          st_nxt     = prfc_pkg::ST_EXIT;
          cnt_nxt    = '0;
          swKind_nxt = 1'b0;
        end
      end
      prfc_pkg::ST_SWRST: begin
        if (cnt_r >= SwCnt) begin
          st_nxt  = prfc_pkg::ST_EXIT;
          cnt_nxt = '0;
        end
      end
      prfc_pkg::ST_EXIT: begin
        if (cnt_r >= ExitCnt) begin
          st_nxt  = prfc_pkg::ST_CLKWAIT;
          cnt_nxt = '0;
        end
      end
      prfc_pkg::ST_CLKWAIT: begin
        // software reset does not restart the plls for the full wait
        if (swKind_r || cnt_r >= ClkCnt) begin
          st_nxt  = prfc_pkg::ST_RUN;
          cnt_nxt = '0;
        end
      end
      prfc_pkg::ST_RUN: begin
        cnt_nxt = '0;
        if (swRstWr) begin
          st_nxt     = prfc_pkg::ST_SWRST;
          swKind_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = prfc_pkg::ST_POR;
      end
    endcase
    // a held-low pin outranks everything but power-on
    if (st_r != prfc_pkg::ST_POR && low_nxt == HwMin) begin
      st_nxt  = prfc_pkg::ST_HOLD;
      cnt_nxt = '0;
    end
  end

  // register the sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r     <= prfc_pkg::ST_POR;
      cnt_r    <= '0;
      low_r    <= '0;
      swKind_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      low_r    <= low_nxt;
      swKind_r <= swKind_nxt;
    end
  end

  // status group: derived from the next state so outputs come from flops
  logic                    inRst, inHwRst, macRel;
  logic                    pd_nxt, iso_nxt, oe_nxt, clkOn_nxt, rdy_nxt, swb_nxt, clr_nxt;
  logic [`PRFC_ADDR_W-1:0] addr_nxt;
  always_comb begin
    inHwRst   = (st_nxt == prfc_pkg::ST_POR) || (st_nxt == prfc_pkg::ST_HOLD);
    inRst     = inHwRst || (st_nxt == prfc_pkg::ST_SWRST);
    macRel    = (st_nxt == prfc_pkg::ST_CLKWAIT) || (st_nxt == prfc_pkg::ST_RUN);
    pd_nxt    = inHwRst;
    iso_nxt   = !macRel;
    oe_nxt    = !inRst && !(st_nxt == prfc_pkg::ST_EXIT && cnt_nxt < ExitCnt - CntOne);
    clkOn_nxt = (st_nxt == prfc_pkg::ST_RUN);
    rdy_nxt   = macRel;
    clr_nxt   = inRst;
    // set only by the software write, cleared at completion
    swb_nxt   = (st_nxt == prfc_pkg::ST_SWRST) ||
                (st_nxt == prfc_pkg::ST_EXIT && swKind_nxt) ||
                (st_nxt == prfc_pkg::ST_CLKWAIT && swKind_nxt);
    addr_nxt  = phyAddr;
    // capture address first in exit, never after a software reset
    if (st_r != prfc_pkg::ST_EXIT && st_nxt == prfc_pkg::ST_EXIT && !swKind_nxt) begin
      addr_nxt = addrStrap;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      powerDown  <= 1'b1;
      macIsolate <= 1'b1;
      lineTxOe   <= 1'b0;
      macClkOn   <= 1'b0;
      mgmtReady  <= 1'b0;
      swRstBit   <= 1'b0;
      latchClr   <= 1'b1;
      phyAddr    <= '0;
    end else begin
      powerDown  <= pd_nxt;
      macIsolate <= iso_nxt;
      lineTxOe   <= oe_nxt;
      macClkOn   <= clkOn_nxt;
      mgmtReady  <= rdy_nxt;
      swRstBit   <= swb_nxt;
      latchClr   <= clr_nxt;
      phyAddr    <= addr_nxt;
    end
  end

  // transmit framing: at 100M ssd on first octet, esd after last nibble
  logic       txEnD_r, txEnD_nxt;      // last cycle's enable
  logic       txSecond_r, txSecond_nxt; // second nibble of ssd/esd due
  prfc_pkg::prfc_sym_t tx_nxt;
  always_comb begin
    txEnD_nxt    = macTxEn && !macIsolate;
    txSecond_nxt = 1'b0;
    tx_nxt.vld   = 1'b1;
    tx_nxt.sym   = speed100 ? `PRFC_IDLE : `PRFC_NLP;
    if (macIsolate) begin
      tx_nxt.vld = 1'b0;
      tx_nxt.sym = 4'h0;
    end else if (txEnD_nxt && !txEnD_r) begin
      tx_nxt.sym   = speed100 ? `PRFC_SSD_J : macTxD;
      txSecond_nxt = speed100;
    end else if (txSecond_r && txEnD_nxt) begin
      tx_nxt.sym   = `PRFC_SSD_K;
    end else if (txEnD_nxt) begin
      tx_nxt.sym   = macTxD;
    end else if (txEnD_r) begin
      tx_nxt.sym   = speed100 ? `PRFC_ESD_T : `PRFC_IDL_10;
      txSecond_nxt = speed100;
    end else if (txSecond_r) begin
      tx_nxt.sym   = `PRFC_ESD_R;
    end
  end

  // receive framing: ssd back to preamble, stop at esd, 10M waits lock
  logic                 rxAct_r, rxAct_nxt;
  prfc_pkg::prfc_nib_t  rx_nxt;
  logic                 link_nxt;
  always_comb begin
    rxAct_nxt  = rxAct_r;
    rx_nxt.vld = 1'b0;
    rx_nxt.nib = 4'h0;
    link_nxt   = rxIdleSeen;
    // gate on the next isolate so data never outlives release
    if (iso_nxt) begin
      rxAct_nxt = 1'b0;
      link_nxt  = 1'b0;
    end else if (!lineRx.vld) begin
      rxAct_nxt = 1'b0;
    end else if (speed100) begin
      if (lineRx.sym == `PRFC_SSD_J || lineRx.sym == `PRFC_SSD_K) begin
        rxAct_nxt  = 1'b1;
        rx_nxt.vld = 1'b1;
        rx_nxt.nib = `PRFC_NIB_PRE;
      end else if (lineRx.sym == `PRFC_ESD_T || lineRx.sym == `PRFC_ESD_R) begin
        rxAct_nxt  = 1'b0;
      end else if (rxAct_r) begin
        rx_nxt.vld = 1'b1;
        rx_nxt.nib = lineRx.sym;
      end
    end else begin
      rxAct_nxt  = rxLock10;
      rx_nxt.vld = rxLock10;
      rx_nxt.nib = rxLock10 ? lineRx.sym : 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txEnD_r    <= 1'b0;
      txSecond_r <= 1'b0;
      lineTx     <= '0;
      rxAct_r    <= 1'b0;
      macRxDv    <= 1'b0;
      macRxD     <= 4'h0;
      linkUp     <= 1'b0;
    end else begin
      txEnD_r    <= txEnD_nxt;
      txSecond_r <= txSecond_nxt;
      lineTx     <= tx_nxt;
      rxAct_r    <= rxAct_nxt;
      macRxDv    <= rx_nxt.vld;
      macRxD     <= rx_nxt.nib;
      linkUp     <= link_nxt;
    end
  end
endmodule : prfc_top

// file: prfc_defines.svh
// timing and field constants for the phy reset and framing control block
`ifndef PRFC_DEFINES_SVH
`define PRFC_DEFINES_SVH
`define PRFC_CLK_NS        100
`define PRFC_CLK_PERIOD_NS 10
`define PRFC_HW_MIN_LOW    5
`define PRFC_EXIT_STEPS_REF 16
`define PRFC_RELEASE_NS    640
`define PRFC_RELEASE_CYC   ((`PRFC_RELEASE_NS) / (`PRFC_CLK_PERIOD_NS))
`define PRFC_POR_US        20
`define PRFC_POR_CYC       (((`PRFC_POR_US) * 1000) / (`PRFC_CLK_PERIOD_NS))
`define PRFC_CLKUP_MS      53
`define PRFC_CLKUP_CYC     (((`PRFC_CLKUP_MS) * 1000000) / (`PRFC_CLK_PERIOD_NS))
`define PRFC_SW_RST_CYC    2
`define PRFC_ADDR_W        5
`define PRFC_CNT_W         23
`define PRFC_NIB_PRE       4'h5
`define PRFC_NIB_SFD       4'hD
`define PRFC_SSD_J         4'h1
`define PRFC_SSD_K         4'h2
`define PRFC_ESD_T         4'h3
`define PRFC_ESD_R         4'h4
`define PRFC_IDLE          4'hF
`define PRFC_IDL_10        4'hE
`define PRFC_NLP           4'hC
`endif

// file: prfc_pkg.sv
// types shared by the phy reset and framing control block
package prfc_pkg;
  // reset sequencer states, gray along the usual path except the power-on to exit step
  typedef enum logic [2:0] {
    ST_POR     = 3'b000,
    ST_HOLD    = 3'b001,
    ST_EXIT    = 3'b011,
    ST_CLKWAIT = 3'b010,
    ST_RUN     = 3'b110,
    ST_SWRST   = 3'b111
  } prfc_state_t;
  // line-side symbol with its valid flag
  typedef struct packed {
    logic       vld;
    logic [3:0] sym;
  } prfc_sym_t;
  // mac-side nibble with its valid flag
  typedef struct packed {
    logic       vld;
    logic [3:0] nib;
  } prfc_nib_t;
endpackage : prfc_pkg

// file: prfc_top_asserts.sv
// checker for reset sequencing at the ports of prfc_top
`include "prfc_defines.svh"
module prfc_top_asserts (
  input wire logic                    mclk,
  input wire logic                    rst_b,
  input wire logic                    ext_rst_low_in,
  input wire logic                    swRstWr,
  input wire logic                    macRxDv,
  input wire logic                    macClkOn,
  input wire logic                    macIsolate,
  input wire logic                    lineTxOe,
  input wire logic                    powerDown,
  input wire logic                    swRstBit,
  input wire logic [`PRFC_ADDR_W-1:0] phyAddr,
  input wire logic                    mgmtReady
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // power-down implies full isolation
  property p_pdIso; powerDown |-> macIsolate && !lineTxOe && !macClkOn; endproperty
  a_pdIso: assert property (p_pdIso) else $error("powerdown without isolation");
  property p_isoLow; macIsolate |-> !macRxDv && !macClkOn; endproperty
  a_isoLow: assert property (p_isoLow) else $error("mac outputs active while isolated");
  // transmitter comes up before mac release
  property p_txFirst; !lineTxOe |-> macIsolate; endproperty
  a_txFirst: assert property (p_txFirst) else $error("mac released before line tx");
  // pin sync of three plus the release limit
  property p_release; $rose(ext_rst_low_in) && powerDown |-> ##[1:67] !macIsolate; endproperty
  a_release: assert property (p_release) else $error("mac release too late");
  property p_run; macClkOn |-> mgmtReady && !macIsolate; endproperty
  a_run: assert property (p_run) else $error("clocks on before mgmt ready");
  property p_swSet; swRstWr && macClkOn |=> swRstBit; endproperty
  a_swSet: assert property (p_swSet) else $error("soft reset bit not set");
  property p_swNoPd; swRstBit |-> !powerDown; endproperty
  a_swNoPd: assert property (p_swNoPd) else $error("soft reset entered powerdown");
  property p_swClr; $fell(swRstBit) |-> macClkOn; endproperty
  a_swClr: assert property (p_swClr) else $error("soft bit cleared early");
  property p_addr; swRstBit |-> $stable(phyAddr); endproperty
  a_addr: assert property (p_addr) else $error("address changed in soft reset");
  cover property (swRstWr && macClkOn);
  cover property ($rose(ext_rst_low_in) && powerDown);
  cover property ($rose(macClkOn));
endmodule : prfc_top_asserts
bind prfc_top prfc_top_asserts i_prfc_top_asserts (.mclk(mclk), .rst_b(rst_b),
  .ext_rst_low_in(ext_rst_low_in), .swRstWr(swRstWr), .macRxDv(macRxDv),
  .macClkOn(macClkOn), .macIsolate(macIsolate), .lineTxOe(lineTxOe),
  .powerDown(powerDown), .swRstBit(swRstBit), .phyAddr(phyAddr), .mgmtReady(mgmtReady));

// file: prfc_mac_model.sv
// mac transmit side model: sends one frame per go pulse
module prfc_mac_model (
  input wire logic mclk,
  input wire logic macClkOn,
  input wire logic go,
  output logic     macTxEn,
  output logic [3:0] macTxD
);
  timeunit 1ns;
  timeprecision 1ns;
  int i; // nibble index within the frame
  initial begin
    macTxEn = 1'b0;
    macTxD  = 4'h0;
    forever begin
      @(negedge mclk);
      // no frame until the phy clocks are valid
      if (go && macClkOn) begin
        // seven preamble nibbles then the start-of-frame nibble
        for (i = 0; i < 8; i++) begin
          macTxEn <= 1'b1;
          macTxD  <= (i == 7) ? 4'hD : 4'h5;
          @(negedge mclk);
        end
        macTxEn <= 1'b0;
        macTxD  <= ~macTxD; // released data must not look held
      end
    end
  end
endmodule : prfc_mac_model

// file: prfc_top_tb_top.sv
// self-checking bench for prfc_top
module prfc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_b, ext_rst_low_in, swRstWr, speed100, go, macTxEn, macRxDv, macClkOn;
  logic macIsolate, lineTxOe, powerDown, swRstBit, mgmtReady, linkUp, lock10, idleSeen;
  logic [3:0] macTxD, macRxD, last;
  logic [4:0] strap, oldAddr, phyAddr;
  prfc_pkg::prfc_sym_t lineRx, lineTx;
  logic [3:0] q[$], rq[$];
  int failures, n_tests, seed, n, cyc, s;
  prfc_top #(.PorCycles(20), .ClkUpCycles(50)) i_prfc_top (.mclk(mclk), .rst_b(rst_b),
    .ext_rst_low_in(ext_rst_low_in), .swRstWr(swRstWr), .addrStrap(strap),
    .speed100(speed100), .macTxEn(macTxEn), .macTxD(macTxD), .lineRx(lineRx),
    .rxLock10(lock10), .rxIdleSeen(idleSeen), .macRxDv(macRxDv), .macRxD(macRxD),
    .macClkOn(macClkOn), .macIsolate(macIsolate), .lineTxOe(lineTxOe), .lineTx(lineTx),
    .powerDown(powerDown), .swRstBit(swRstBit), .phyAddr(phyAddr),
    .mgmtReady(mgmtReady), .linkUp(linkUp), .latchClr());
  prfc_mac_model i_prfc_mac_model (.mclk(mclk), .macClkOn(macClkOn), .go(go),
    .macTxEn(macTxEn), .macTxD(macTxD));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // compare one value, count it
  task automatic chk(input string nm, input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // adjacent pair in the captured symbols, a==b means single
  function automatic logic has(input logic [3:0] a, input logic [3:0] b);
    for (int i = 0; i + 1 < q.size(); i++)
      if (q[i] == a && (a == b || q[i+1] == b)) return 1'b1;
    return 1'b0;
  endfunction : has
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic waitOn;
    while (!macClkOn) @(negedge mclk);
  endtask : waitOn
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    seed = 32'hB1CA;
    {rst_b, swRstWr, speed100, go} = 4'h0;
    ext_rst_low_in = 1'b1;
    {lock10, idleSeen} = 2'h3;
    lineRx = '{vld: 1'b0, sym: 4'hF};
    strap = 5'($random(seed));
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    waitOn();
    chk("addr", phyAddr, strap);
    chk("swbit", swRstBit, 1'b0);
    chk("txoe", lineTxOe, 1'b1);
    chk("mgmt", mgmtReady, 1'b1);
    $display("power-on test done");
    oldAddr = strap;
    strap = 5'($random(seed));
    swRstWr = 1'b1;
    @(negedge mclk);
    swRstWr = 1'b0;
    chk("swbit", swRstBit, 1'b1);
    chk("pd", powerDown, 1'b0);
    chk("clk", macClkOn, 1'b0);
    waitOn();
    chk("swbit", swRstBit, 1'b0);
    chk("addr", phyAddr, oldAddr);
    $display("soft reset test done");
    ext_rst_low_in = 1'b0;
    repeat (9) @(negedge mclk);
    chk("iso", macIsolate, 1'b1);
    chk("pd", powerDown, 1'b1);
    chk("txoe", lineTxOe, 1'b0);
    ext_rst_low_in = 1'b1;
    for (n = 0; macIsolate && n < 99; n++) @(negedge mclk);
    chk("release", 5'(n <= 67), 1'b1);
    waitOn();
    chk("addr", phyAddr, strap);
    chk("swbit", swRstBit, 1'b0);
    $display("pin reset test done");
    for (s = 0; s < 2; s++) begin
      speed100 = s[0];
      q = {};
      go <= 1'b1;
      @(negedge mclk);
      go <= 1'b0;
      repeat (40) begin
        @(negedge mclk);
        q.push_back(lineTx.vld ? lineTx.sym : 4'h0);
      end
      chk("ssd", has(4'h1, 4'h2), s[0]);
      chk("esd", has(4'h3, 4'h4), s[0]);
      chk("sfd", has(4'h5, 4'hD), 1'b1);
      if (s == 1) chk("idle", has(4'hF, 4'hF), 1'b1);
      else chk("idl", has(4'hE, 4'hE), 1'b1);
    end
    $display("transmit framing test done");
    rq = {};
    for (n = 0; n < 24; n++) begin
      if (n > 1 && n < 8) last = 4'h6 + 4'($random(seed) & 3);
      lineRx = '{vld: n < 10, sym: n == 0 ? 4'h1 : n == 1 ? 4'h2 : n == 8 ? 4'h3
                 : n == 9 ? 4'h4 : n < 8 ? last : 4'hF};
      @(negedge mclk);
      if (macRxDv) rq.push_back(macRxD);
    end
    chk("rxcount", 5'(rq.size() > 2), 1'b1);
    chk("rxpre", rq[0], 4'h5);
    chk("rxlast", rq[$], last);
    chk("link", linkUp, 1'b1);
    idleSeen = 1'b0;
    repeat (2) @(negedge mclk);
    chk("linkdn", linkUp, 1'b0);
    $display("receive framing test done");
    test_done();
  end
endmodule : prfc_top_tb_top
